// ---- design/pcs_pkg.sv ----
/*
  Package of the pre-driver configuration store: word map, field layout,
  values after reset, timing figures and the single-error-correcting,
  double-error-detecting code of the stored words.
  Assumes a 100 MHz system clock; every user writes pcs_pkg::name.
*/
package pcs_pkg;

  localparam int WORDS = 6;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CODE_W = 13;
  localparam int FET_W = 3;
  localparam int CNT_W = 16;
  localparam int WCNT_W = 16;

  // word offsets
  localparam logic [2:0] ADDR_RSVD_ZERO = 3'h0;
  localparam logic [2:0] ADDR_RSVD_ONE = 3'h1;
  localparam logic [2:0] ADDR_DRIVER_TIMING = 3'h2;
  localparam logic [2:0] ADDR_SENSE_BLANKING = 3'h3;
  localparam logic [2:0] ADDR_PROTECTION_PUMP = 3'h4;
  localparam logic [2:0] ADDR_INTERFACE_PERMIT = 3'h5;
  localparam logic [2:0] ADDR_LAST = 3'h5;

  // field positions
  localparam int DEAD_LSB = 5;
  localparam int DSTH_LSB = 2;
  localparam int BREF_BIT = 1;
  localparam int BLANK_LSB = 6;
  localparam int SPEED_BIT = 5;
  localparam int GAIN_LSB = 1;
  localparam int REG_OV_BIT = 7;
  localparam int DS_REACT_BIT = 6;
  localparam int DS_CMP_BIT = 5;
  localparam int GS_CMP_BIT = 4;
  localparam int TRICKLE_BIT = 3;
  localparam int BOOST_BIT = 2;
  localparam int PERMIT_BIT = 7;

  // field values after reset
  localparam logic [2:0] DEAD_RST = 3'h3;
  localparam logic [2:0] DSTH_RST = 3'h7;
  localparam logic [1:0] BLANK_RST = 2'h2;
  localparam logic [2:0] GAIN_RST = 3'h3;
  localparam logic BREF_RST = 1'b0;
  localparam logic SPEED_RST = 1'b0;
  localparam logic PERMIT_RST = 1'b1;
  localparam logic REG_OV_RST = 1'b1;
  localparam logic DS_REACT_RST = 1'b1;
  localparam logic DS_CMP_RST = 1'b1;
  localparam logic GS_CMP_RST = 1'b1;
  localparam logic BOOST_RST = 1'b1;
  localparam logic TRICKLE_RST = 1'b0;
  localparam logic FIXED_ONE = 1'b1;

  localparam logic [7:0] DEF_WORD [WORDS] = '{
    8'h00,
    8'h00,
    {DEAD_RST, DSTH_RST, BREF_RST, 1'b0},
    {BLANK_RST, SPEED_RST, 1'b0, GAIN_RST, 1'b0},
    {REG_OV_RST, DS_REACT_RST, DS_CMP_RST, GS_CMP_RST, TRICKLE_RST, BOOST_RST, 2'h0},
    {PERMIT_RST, FIXED_ONE, 6'h00}
  };
  // writable bits per word, and bits held at one
  localparam logic [7:0] WR_MASK [WORDS] = '{8'h00, 8'h00, 8'hFE, 8'hEE, 8'hFC, 8'h80};
  localparam logic [7:0] FIX_ONES [WORDS] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_MIN_NS = 256000;
  localparam int PULSE_MAX_NS = 512000;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_PERIOD_NS;
  localparam int NV_WRITE_CYC = 100;

  localparam int DPOS [DATA_W] = '{3, 5, 6, 7, 9, 10, 11, 12};

  function automatic logic [12:0] secded_enc(input logic [7:0] d);
    logic [12:0] cw;
    cw = '0;
    for (int i = 0; i < DATA_W; i++) cw[DPOS[i]] = d[i];
    for (int p = 0; p < 4; p++) begin
      for (int i = 1; i < CODE_W; i++) begin
        if (i[p] && (i != (1 << p))) cw[1 << p] = cw[1 << p] ^ cw[i];
      end
    end
    cw[0] = ^cw[12:1];
    return cw;
  endfunction

  function automatic logic [7:0] secded_dec(input logic [12:0] cw, output logic ded);
    logic [3:0] syn;
    logic [12:0] fix;
    logic [7:0] d;
    syn = '0;
    for (int i = 1; i < CODE_W; i++) begin
      if (cw[i]) syn = syn ^ 4'(i);
    end
    fix = cw;
    ded = 1'b0;
    if (syn != 4'h0) begin
      if ((^cw) && (syn <= 4'hC)) fix[syn] = ~fix[syn];
      else ded = 1'b1;
    end
    for (int i = 0; i < DATA_W; i++) d[i] = fix[DPOS[i]];
    return d;
  endfunction

endpackage

// ---- design/pcs_sync.sv ----
/*
  Two-stage synchroniser for a group of pin levels.
  Assumes inputs are asynchronous to clk; only the second stage is read.
*/
`timescale 1ns/1ps
module pcs_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta_reg <= din;
      dout <= meta_reg;
    end
  end

endmodule

// ---- design/pcs_top.sv ----
/*
  Configuration store and mode control of a three-phase FET pre-driver:
  protected word store, entry to and exit from serial programming mode,
  copy of stored words into working registers, bridge blocking.
  Assumes pins arrive asynchronously, the serial frame logic and the
  diagnostic error logic sit on clk and use the store port below.
*/
`timescale 1ns/1ps
module pcs_top #(
  parameter int PULSE_MIN_CYCLES = pcs_pkg::PULSE_MIN_CYC,
  parameter int PULSE_MAX_CYCLES = pcs_pkg::PULSE_MAX_CYC,
  parameter int NV_WRITE_CYCLES = pcs_pkg::NV_WRITE_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic diagnostic_line_in,
  input wire logic [pcs_pkg::FET_W-1:0] high_side_inputs,
  input wire logic [pcs_pkg::FET_W-1:0] low_side_inputs,
  input wire logic errors_pending,
  input wire logic regulator_over_voltage,
  input wire logic drain_source_error,
  input wire logic store_rd,
  input wire logic store_wr,
  input wire logic [pcs_pkg::ADDR_W-1:0] store_addr,
  input wire logic [pcs_pkg::DATA_W-1:0] store_wdata,
  output logic [pcs_pkg::DATA_W-1:0] store_rdata,
  output logic store_ack,
  output logic store_ded,
  output logic store_fault,
  output logic prog_mode,
  output logic diagnostic_line_out,
  output logic diagnostic_line_oe,
  output logic bridge_block,
  output logic [2:0] dead_time,
  output logic [2:0] drain_source_threshold,
  output logic [1:0] blank_time,
  output logic [2:0] sense_amp_gain,
  output logic boost_reference_select,
  output logic diag_speed,
  output logic serial_permit,
  output logic regulator_over_bridge_react,
  output logic drain_source_bridge_react,
  output logic drain_source_compare_on,
  output logic gate_source_under_compare_on,
  output logic boost_pump_on,
  output logic trickle_pump_on
);

  typedef enum logic [1:0] {
    PCS_COPY,
    PCS_NORMAL,
    PCS_PROG,
    PCS_DRAIN
  } pcs_state_t;

  localparam logic [pcs_pkg::CNT_W-1:0] MIN_CNT = pcs_pkg::CNT_W'(PULSE_MIN_CYCLES);
  localparam logic [pcs_pkg::CNT_W-1:0] MAX_CNT = pcs_pkg::CNT_W'(PULSE_MAX_CYCLES);
  localparam logic [pcs_pkg::WCNT_W-1:0] WR_CNT = pcs_pkg::WCNT_W'(NV_WRITE_CYCLES);

  // synchronised pins
  logic enable_s;
  logic diag_s;
  logic [pcs_pkg::FET_W-1:0] high_s;
  logic [pcs_pkg::FET_W-1:0] low_s;
  logic reg_ov_s;
  logic ds_err_s;

  pcs_sync #(.W(1), .RST_VAL(1'b0)) u_sync_en (
    .clk(clk), .reset(reset), .din(enable_pin), .dout(enable_s)
  );
  pcs_sync #(.W(1), .RST_VAL(1'b1)) u_sync_diag (
    .clk(clk), .reset(reset), .din(diagnostic_line_in), .dout(diag_s)
  );
  pcs_sync #(.W(pcs_pkg::FET_W), .RST_VAL('0)) u_sync_high (
    .clk(clk), .reset(reset), .din(high_side_inputs), .dout(high_s)
  );
  pcs_sync #(.W(pcs_pkg::FET_W), .RST_VAL('1)) u_sync_low (
    .clk(clk), .reset(reset), .din(low_side_inputs), .dout(low_s)
  );
  pcs_sync #(.W(1), .RST_VAL(1'b0)) u_sync_ov (
    .clk(clk), .reset(reset), .din(regulator_over_voltage), .dout(reg_ov_s)
  );
  pcs_sync #(.W(1), .RST_VAL(1'b0)) u_sync_ds (
    .clk(clk), .reset(reset), .din(drain_source_error), .dout(ds_err_s)
  );

  // state
  pcs_state_t state_reg;
  pcs_state_t state_next;
  logic [pcs_pkg::ADDR_W-1:0] copy_idx_reg;
  logic [pcs_pkg::CNT_W-1:0] low_cnt_reg;
  logic diag_prev_reg;
  logic [pcs_pkg::WCNT_W-1:0] wr_cnt_reg;
  logic [pcs_pkg::ADDR_W-1:0] wr_addr_reg;
  logic [pcs_pkg::DATA_W-1:0] wr_data_reg;
  logic [pcs_pkg::CODE_W-1:0] mem [pcs_pkg::WORDS];

  // protected store image of the defaults
  function automatic logic [pcs_pkg::CODE_W-1:0] def_code(input int i);
    return pcs_pkg::secded_enc(pcs_pkg::DEF_WORD[i]);
  endfunction

  // mode entry qualification
  wire fets_idle = (high_s == '0) && (low_s == '1);
  wire pulse_end = diag_s && !diag_prev_reg;
  wire pulse_ok = (low_cnt_reg >= MIN_CNT) && (low_cnt_reg <= MAX_CNT);
  wire entry_ok = pulse_end && pulse_ok && !enable_s && !errors_pending && fets_idle;
  wire in_normal = (state_reg == PCS_NORMAL);
  wire in_prog = (state_reg == PCS_PROG);
  wire write_busy = (wr_cnt_reg != '0);
  wire write_last = (wr_cnt_reg == pcs_pkg::WCNT_W'(1));
  wire addr_ok = (store_addr <= pcs_pkg::ADDR_LAST);
  // no second take while an answer stands and the request is still held
  wire access_ok = in_prog && serial_permit && !write_busy && addr_ok && !enable_s && !store_ack;
  wire rd_take = access_ok && store_rd;
  wire wr_take = access_ok && store_wr && !store_rd;
  wire copy_last = (copy_idx_reg == pcs_pkg::ADDR_LAST);

  // store read and decode paths
  wire [pcs_pkg::CODE_W-1:0] rd_code = mem[rd_take ? store_addr : copy_idx_reg];
  logic [pcs_pkg::DATA_W-1:0] rd_data;
  logic rd_ded;
  always_comb begin
    rd_data = pcs_pkg::secded_dec(rd_code, rd_ded);
  end

  // write value: reserved bits forced, permit bit only clears
  logic [pcs_pkg::DATA_W-1:0] wr_value;
  logic [pcs_pkg::DATA_W-1:0] old_data;
  logic old_ded;
  always_comb begin
    old_data = pcs_pkg::secded_dec(mem[store_addr], old_ded);
    wr_value = (store_wdata & pcs_pkg::WR_MASK[store_addr]) | pcs_pkg::FIX_ONES[store_addr];
    if (store_addr == pcs_pkg::ADDR_INTERFACE_PERMIT) begin
      wr_value[pcs_pkg::PERMIT_BIT] = store_wdata[pcs_pkg::PERMIT_BIT] & old_data[pcs_pkg::PERMIT_BIT];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PCS_COPY: begin
        if (copy_last) state_next = PCS_NORMAL;
      end
      PCS_NORMAL: begin
        if (entry_ok) state_next = PCS_PROG;
      end
      PCS_PROG: begin
        if (enable_s) state_next = PCS_DRAIN;
      end
      PCS_DRAIN: begin
        if (!write_busy) state_next = PCS_COPY;
      end
      default: state_next = PCS_COPY;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= PCS_COPY;
      copy_idx_reg <= '0;
      diag_prev_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      copy_idx_reg <= (state_reg == PCS_COPY && !copy_last) ? copy_idx_reg + 3'h1 : '0;
      diag_prev_reg <= diag_s;
    end
  end

  // low level length, counted only in normal mode, saturating
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt_reg <= '0;
    end else if (!in_normal || diag_s) begin
      low_cnt_reg <= '0;
    end else if (low_cnt_reg <= MAX_CNT) begin
      low_cnt_reg <= low_cnt_reg + 16'h0001;
    end
  end

  // nonvolatile write timer and array
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_cnt_reg <= '0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else if (wr_take) begin
      wr_cnt_reg <= WR_CNT;
      wr_addr_reg <= store_addr;
      wr_data_reg <= wr_value;
    end else if (write_busy) begin
      wr_cnt_reg <= wr_cnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < pcs_pkg::WORDS; i++) mem[i] <= def_code(i);
    end else if (write_last) begin
      mem[wr_addr_reg] <= pcs_pkg::secded_enc(wr_data_reg);
    end
  end

  // serial-side answers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      store_rdata <= '0;
      store_ack <= 1'b0;
      store_ded <= 1'b0;
    end else begin
      store_ack <= rd_take || write_last;
      if (rd_take) begin
        store_rdata <= rd_data;
        store_ded <= rd_ded;
      end
    end
  end

  // working registers, defaults until first copy
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dead_time <= pcs_pkg::DEAD_RST;
      drain_source_threshold <= pcs_pkg::DSTH_RST;
      boost_reference_select <= pcs_pkg::BREF_RST;
      blank_time <= pcs_pkg::BLANK_RST;
      diag_speed <= pcs_pkg::SPEED_RST;
      sense_amp_gain <= pcs_pkg::GAIN_RST;
      regulator_over_bridge_react <= pcs_pkg::REG_OV_RST;
      drain_source_bridge_react <= pcs_pkg::DS_REACT_RST;
      drain_source_compare_on <= pcs_pkg::DS_CMP_RST;
      gate_source_under_compare_on <= pcs_pkg::GS_CMP_RST;
      trickle_pump_on <= pcs_pkg::TRICKLE_RST;
      boost_pump_on <= pcs_pkg::BOOST_RST;
      serial_permit <= pcs_pkg::PERMIT_RST;
    end else if (state_reg == PCS_COPY) begin
      case (copy_idx_reg)
        pcs_pkg::ADDR_DRIVER_TIMING: begin
          dead_time <= rd_data[pcs_pkg::DEAD_LSB +: 3];
          drain_source_threshold <= rd_data[pcs_pkg::DSTH_LSB +: 3];
          boost_reference_select <= rd_data[pcs_pkg::BREF_BIT];
        end
        pcs_pkg::ADDR_SENSE_BLANKING: begin
          blank_time <= rd_data[pcs_pkg::BLANK_LSB +: 2];
          diag_speed <= rd_data[pcs_pkg::SPEED_BIT];
          sense_amp_gain <= rd_data[pcs_pkg::GAIN_LSB +: 3];
        end
        pcs_pkg::ADDR_PROTECTION_PUMP: begin
          regulator_over_bridge_react <= rd_data[pcs_pkg::REG_OV_BIT];
          drain_source_bridge_react <= rd_data[pcs_pkg::DS_REACT_BIT];
          drain_source_compare_on <= rd_data[pcs_pkg::DS_CMP_BIT];
          gate_source_under_compare_on <= rd_data[pcs_pkg::GS_CMP_BIT];
          trickle_pump_on <= rd_data[pcs_pkg::TRICKLE_BIT];
          boost_pump_on <= rd_data[pcs_pkg::BOOST_BIT];
        end
        pcs_pkg::ADDR_INTERFACE_PERMIT: begin
          serial_permit <= rd_data[pcs_pkg::PERMIT_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // double error seen during copy, cleared when a new copy starts
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      store_fault <= 1'b0;
    end else if (state_reg == PCS_COPY) begin
      store_fault <= (copy_idx_reg != '0 && store_fault) || rd_ded;
    end
  end

  // mode, diagnostic line and bridge outputs
  wire next_busy = (state_next == PCS_COPY) || (state_next == PCS_DRAIN);
  wire ov_block = reg_ov_s && regulator_over_bridge_react;
  wire ds_block = ds_err_s && drain_source_compare_on && drain_source_bridge_react;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_mode <= 1'b0;
      diagnostic_line_out <= 1'b0;
      diagnostic_line_oe <= 1'b1;
      bridge_block <= 1'b1;
    end else begin
      prog_mode <= (state_next == PCS_PROG);
      diagnostic_line_out <= 1'b0;
      diagnostic_line_oe <= next_busy;
      bridge_block <= (state_next != PCS_NORMAL) || ov_block || ds_block;
    end
  end

endmodule

// ---- testbench/pcs_mcu_model.sv ----
/*
  Microcontroller model at the pre-driver pins: enable, FET inputs and an
  open-drain pull on the diagnostic line. Assumes the bench calls its tasks.
*/
`timescale 1ns/1ps
module pcs_mcu_model (
  input wire logic clk,
  output logic enable_pin,
  output logic [pcs_pkg::FET_W-1:0] high_side_inputs,
  output logic [pcs_pkg::FET_W-1:0] low_side_inputs,
  output logic diag_pull_low
);
  initial begin
    enable_pin = 1'b1;
    high_side_inputs = 3'h0;
    low_side_inputs = 3'h7;
    diag_pull_low = 1'b0;
  end
  // pins settle first, then a low pulse of len cycles
  task automatic attempt(input int len, input logic en, input logic [2:0] hs, input logic [2:0] ls);
    @(posedge clk);
    enable_pin <= en;
    high_side_inputs <= hs;
    low_side_inputs <= ls;
    repeat (4) @(posedge clk);
    diag_pull_low <= 1'b1;
    repeat (len) @(posedge clk);
    diag_pull_low <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic leave();
    @(posedge clk);
    enable_pin <= 1'b1;
  endtask
endmodule

// ---- testbench/pcs_top_chk.sv ----
/*
  Checker bound into pcs_top: mode entry and exit, copy, bridge blocking, store port.
  Assumes one clock domain and an asynchronous active-high reset.
*/
`timescale 1ns/1ps
module pcs_top_chk #(
  parameter int NV_WRITE_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic errors_pending,
  input wire logic [pcs_pkg::FET_W-1:0] high_side_inputs,
  input wire logic [pcs_pkg::FET_W-1:0] low_side_inputs,
  input wire logic regulator_over_voltage,
  input wire logic drain_source_error,
  input wire logic store_ack,
  input wire logic prog_mode,
  input wire logic diagnostic_line_out,
  input wire logic diagnostic_line_oe,
  input wire logic bridge_block,
  input wire logic serial_permit,
  input wire logic regulator_over_bridge_react,
  input wire logic drain_source_bridge_react,
  input wire logic drain_source_compare_on
);
  localparam int EXIT_MAX = NV_WRITE_CYCLES + 12;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_entry_ok;
    $rose(prog_mode) |-> !enable_pin && !errors_pending && high_side_inputs == 3'h0 && low_side_inputs == 3'h7;
  endproperty
  a_entry_ok: assert property (p_entry_ok) else $error("entry without idle conditions");
  property p_exit_on_enable; prog_mode && enable_pin |-> ##[1:4] !prog_mode; endproperty
  a_exit_on_enable: assert property (p_exit_on_enable) else $error("enable did not end programming");
  property p_exit_copy;
    $fell(prog_mode) |-> (diagnostic_line_oe && bridge_block) [*5] ##[1:EXIT_MAX] !diagnostic_line_oe;
  endproperty
  a_exit_copy: assert property (p_exit_copy) else $error("exit drain or copy timing wrong");
  property p_oe_low; diagnostic_line_oe |-> !diagnostic_line_out; endproperty
  a_oe_low: assert property (p_oe_low) else $error("diagnostic line driven high");
  property p_prog_blocks; prog_mode |-> bridge_block && !diagnostic_line_oe; endproperty
  a_prog_blocks: assert property (p_prog_blocks) else $error("bridge free in programming");
  property p_permit; !$rose(serial_permit); endproperty
  a_permit: assert property (p_permit) else $error("serial permit went from 0 to 1");
  property p_no_ack_normal; !prog_mode && !diagnostic_line_oe |=> !store_ack; endproperty
  a_no_ack_normal: assert property (p_no_ack_normal) else $error("store answered in normal mode");
  property p_ack_pulse; store_ack |=> !store_ack; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("store answer longer than one cycle");
  property p_ov_block;
    (regulator_over_voltage && regulator_over_bridge_react) [*4] |-> bridge_block;
  endproperty
  a_ov_block: assert property (p_ov_block) else $error("overvoltage did not block");
  property p_ds_block;
    (drain_source_error && drain_source_compare_on && drain_source_bridge_react) [*4] |-> bridge_block;
  endproperty
  a_ds_block: assert property (p_ds_block) else $error("drain-source error did not block");
  property p_unblock;
    (!regulator_over_voltage && !drain_source_error && !prog_mode && !diagnostic_line_oe) [*4] |-> !bridge_block;
  endproperty
  a_unblock: assert property (p_unblock) else $error("bridge blocked without cause");
  c_entry: cover property ($rose(prog_mode));
  c_ack: cover property (store_ack);
  c_copy_done: cover property ($fell(diagnostic_line_oe));
  c_exit: cover property ($fell(prog_mode));
endmodule

bind pcs_top pcs_top_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .clk, .reset, .enable_pin, .errors_pending, .high_side_inputs, .low_side_inputs,
  .regulator_over_voltage, .drain_source_error, .store_ack, .prog_mode, .diagnostic_line_out,
  .diagnostic_line_oe, .bridge_block, .serial_permit, .regulator_over_bridge_react,
  .drain_source_bridge_react, .drain_source_compare_on
);

// ---- testbench/tb_pcs_top.sv ----
/*
  Self-checking bench for pcs_top: defaults, entry conditions, store port,
  exit with a pending write, protection. Assumes the model and bound checker.
*/
`timescale 1ns/1ps
module tb_pcs_top;
  typedef struct {int len; logic en; logic [2:0] hs; logic [2:0] ls; logic errs; logic exp;} pcs_row_t;
  localparam logic [18:0] DEF_WORK = {3'h3, 3'h7, 2'h2, 3'h3, 1'b0, 1'b0, 7'h7E};
  localparam logic [18:0] NEW_WORK = {3'h7, 3'h7, 2'h0, 3'h0, 1'b1, 1'b0, 7'h00};
  localparam logic [7:0] DEF_WORDS [6] = '{8'h00, 8'h00, 8'h7C, 8'h86, 8'hF4, 8'hC0};
  pcs_row_t rows [9] = '{'{19, 1'b0, 3'h0, 3'h7, 1'b0, 1'b0}, '{20, 1'b0, 3'h0, 3'h7, 1'b0, 1'b1},
    '{40, 1'b0, 3'h0, 3'h7, 1'b0, 1'b1}, '{41, 1'b0, 3'h0, 3'h7, 1'b0, 1'b0}, '{30, 1'b1, 3'h0, 3'h7, 1'b0, 1'b0},
    '{30, 1'b0, 3'h1, 3'h7, 1'b0, 1'b0}, '{30, 1'b0, 3'h0, 3'h3, 1'b0, 1'b0}, '{30, 1'b0, 3'h0, 3'h7, 1'b1, 1'b0},
    '{30, 1'b0, 3'h0, 3'h7, 1'b0, 1'b1}};
  // address, data written, data read back
  logic [18:0] wrows [5] = '{{3'h2, 8'hFF, 8'hFE}, {3'h4, 8'h03, 8'h00}, {3'h5, 8'h00, 8'h40},
    {3'h5, 8'h80, 8'h40}, {3'h1, 8'hFF, 8'h00}};
  logic clk, reset, errors_pending, regulator_over_voltage, drain_source_error, store_rd, store_wr, ok;
  logic [2:0] store_addr;
  logic [7:0] store_wdata, rdv;
  int bad_count, n_tests, k;
  wire logic enable_pin, diag_pull_low, store_ack, store_ded, store_fault, prog_mode, diagnostic_line_out;
  wire logic diagnostic_line_oe;
  wire logic bridge_block, bref, speed, diag_line;
  wire logic [2:0] high_side_inputs, low_side_inputs, dead_time, drain_source_threshold, sense_amp_gain;
  wire logic [1:0] blank_time;
  wire logic [7:0] store_rdata;
  wire logic [6:0] flags;
  wire logic [18:0] work;
  // open-drain line with pull-up
  assign diag_line = !(diag_pull_low || (diagnostic_line_oe && !diagnostic_line_out));
  assign work = {dead_time, drain_source_threshold, blank_time, sense_amp_gain, bref, speed, flags};

  pcs_top #(.PULSE_MIN_CYCLES(20), .PULSE_MAX_CYCLES(40), .NV_WRITE_CYCLES(8)) dut (
    .clk, .reset, .enable_pin, .diagnostic_line_in(diag_line), .high_side_inputs, .low_side_inputs,
    .errors_pending, .regulator_over_voltage, .drain_source_error, .store_rd, .store_wr, .store_addr,
    .store_wdata, .store_rdata, .store_ack, .store_ded, .store_fault, .prog_mode, .diagnostic_line_out,
    .diagnostic_line_oe, .bridge_block, .dead_time, .drain_source_threshold, .blank_time, .sense_amp_gain,
    .boost_reference_select(bref), .diag_speed(speed), .serial_permit(flags[6]),
    .regulator_over_bridge_react(flags[5]), .drain_source_bridge_react(flags[4]),
    .drain_source_compare_on(flags[3]), .gate_source_under_compare_on(flags[2]),
    .boost_pump_on(flags[1]), .trickle_pump_on(flags[0]));
  pcs_mcu_model mcu (.clk, .enable_pin, .high_side_inputs, .low_side_inputs, .diag_pull_low);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // request held until acknowledged or for at most 30 cycles, then idle
  task automatic xfer(input logic wr, input logic [2:0] a, input logic [7:0] wd);
    ok = 1'b0;
    @(posedge clk);
    store_rd <= !wr;
    store_wr <= wr;
    store_addr <= a;
    store_wdata <= wd;
    for (int i = 0; i < 30 && !ok; i++) begin
      @(posedge clk);
      if (store_ack === 1'b1) begin
        ok = 1'b1;
        rdv = store_rdata;
      end
    end
    store_rd <= 1'b0;
    store_wr <= 1'b0;
    repeat (wr ? 12 : 3) @(posedge clk);
  endtask

  task automatic wait_ready();
    // drain or copy must start before its end is awaited
    for (int i = 0; i < 8 && diagnostic_line_oe !== 1'b1; i++) @(posedge clk);
    for (int i = 0; i < 60 && diagnostic_line_oe !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    check(diagnostic_line_oe, 1'b0);
  endtask

  task automatic tally_and_finish();
    $display("counts: %0d comparisons, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #400000;
    bad_count++;
    tally_and_finish();
  end

  initial begin
    {reset, errors_pending, regulator_over_voltage, drain_source_error, store_rd, store_wr} = 6'h20;
    store_addr = 3'h0;
    store_wdata = 8'h00;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    check(work, DEF_WORK);
    check({bridge_block, diagnostic_line_oe, prog_mode}, 3'h6);
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    repeat (3) @(posedge clk);
    check(bridge_block, 1'b1);
    wait_ready();
    check({bridge_block, work}, {1'b0, DEF_WORK});
    $display("test reset done");
    regulator_over_voltage <= 1'b1;
    repeat (5) @(posedge clk);
    check(bridge_block, 1'b1);
    regulator_over_voltage <= 1'b0;
    drain_source_error <= 1'b1;
    repeat (5) @(posedge clk);
    check(bridge_block, 1'b1);
    drain_source_error <= 1'b0;
    repeat (5) @(posedge clk);
    check(bridge_block, 1'b0);
    xfer(1'b0, 3'h2, 8'h00);
    check(ok, 1'b0);
    $display("test protection done");
    for (k = 0; k < 9; k++) begin
      errors_pending <= rows[k].errs;
      mcu.attempt(rows[k].len, rows[k].en, rows[k].hs, rows[k].ls);
      check(prog_mode, rows[k].exp);
      if (rows[k].exp && k < 8) begin
        mcu.leave();
        wait_ready();
      end
    end
    $display("test entry done");
    for (k = 0; k < 6; k++) begin
      xfer(1'b0, k[2:0], 8'h00);
      check({ok, store_ded, rdv}, {2'h2, DEF_WORDS[k]});
    end
    xfer(1'b0, 3'h6, 8'h00);
    check(ok, 1'b0);
    for (k = 0; k < 5; k++) begin
      xfer(1'b1, wrows[k][18:16], wrows[k][15:8]);
      check(ok, 1'b1);
      xfer(1'b0, wrows[k][18:16], 8'h00);
      check(rdv, wrows[k][7:0]);
    end
    $display("test store done");
    fork
      xfer(1'b1, 3'h3, 8'h00);
      begin
        repeat (2) @(posedge clk);
        mcu.leave();
        repeat (5) @(posedge clk);
        check({prog_mode, diagnostic_line_oe, bridge_block, diag_line}, 4'h6);
      end
    join
    wait_ready();
    check({store_fault, work}, {1'b0, NEW_WORK});
    regulator_over_voltage <= 1'b1;
    drain_source_error <= 1'b1;
    repeat (5) @(posedge clk);
    check(bridge_block, 1'b0);
    regulator_over_voltage <= 1'b0;
    drain_source_error <= 1'b0;
    $display("test exit done");
    mcu.attempt(30, 1'b0, 3'h0, 3'h7);
    check(prog_mode, 1'b1);
    xfer(1'b0, 3'h2, 8'h00);
    check(ok, 1'b0);
    mcu.leave();
    wait_ready();
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    check(work, DEF_WORK);
    reset <= 1'b0;
    wait_ready();
    check(work, DEF_WORK);
    $display("test permit and second reset done");
    tally_and_finish();
  end
endmodule
